// File: rtl/serial_port_consts.svh
// Purpose: offsets, field positions, reset values and divider counts of the serial port
// Assumes: 8-bit byte addresses, 32-bit data words
// Notes: definitions only
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH

// register byte addresses
`define SP_CTRL_OFS 8'h98
`define SP_BUF_OFS 8'h9c
`define SP_CFG_OFS 8'ha0

// control register fields
`define SP_CTRL_RESET 8'h00
`define SP_RXDONE_BIT 0
`define SP_TXDONE_BIT 1
`define SP_RB8_BIT 2
`define SP_TB8_BIT 3
`define SP_REN_BIT 4
`define SP_MPE_BIT 5
`define SP_SML_BIT 6
`define SP_SMH_BIT 7

// configuration register fields
`define SP_CFG_RESET 6'h00
`define SP_VIEW_BIT 0
`define SP_FAST_BIT 1
`define SP_M0HI_BIT 2
`define SP_M0TMR_BIT 3
`define SP_DBL_BIT 4
`define SP_T2SEL_BIT 5
`define SP_TXBUSY_BIT 8
`define SP_RXBUSY_BIT 9

// shift-register mode bit periods in system clocks
`define SP_M0_COMPAT_SLOW 3'd6
`define SP_M0_COMPAT_FAST 3'd3
`define SP_M0_FAST_SLOW 3'd4
`define SP_M0_FAST_FAST 3'd2

// oversampling: last tick and sample point of a bit; data and frame bit counts
`define SP_OS_LAST 4'hf
`define SP_OS_MID 4'h7
`define SP_BITS8 4'h8
`define SP_BITS9 4'h9
`define SP_FRAME10 4'ha
`define SP_FRAME11 4'hb

`endif

// File: rtl/serial_port_pkg.sv
// Purpose: shared types and decode helpers of the serial port
// Assumes: constants come from serial_port_consts.svh
// Notes: no storage here
package serial_port_pkg;

    typedef logic [1:0] sp_mode_t;

    typedef enum logic [1:0] {
        MODE_SHIFT,
        MODE_UART8,
        MODE_UART9_FIXED,
        MODE_UART9_VAR
    } sp_mode_e;

    typedef enum logic [2:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP,
        RX_SHIFT
    } rx_state_e;

    // nine data bits on the line
    function automatic logic is_nine_bit(input sp_mode_t mode);
        return mode[1];
    endfunction

    // bit rate comes from a timer overflow
    function automatic logic is_timer_rate(input sp_mode_t mode);
        return mode[0];
    endfunction

endpackage

// File: rtl/baud_if.sv
// Purpose: carries rate settings to the baud generator and its ticks back
// Assumes: single clock domain
// Notes: gen modport drives the ticks, user modport the settings
`timescale 1ns/1ps
`default_nettype none
interface baud_if;
    import serial_port_pkg::*;
    sp_mode_t mode;
    logic fast;
    logic m0_hi;
    logic m0_tmr;
    logic dbl;
    logic t2_sel;
    logic os_tick;
    logic m0_fall;
    logic m0_rise;

    modport gen (input mode, fast, m0_hi, m0_tmr, dbl, t2_sel,
        output os_tick, m0_fall, m0_rise);
    modport user (output mode, fast, m0_hi, m0_tmr, dbl, t2_sel,
        input os_tick, m0_fall, m0_rise);
endinterface
`default_nettype wire

// File: rtl/baud_gen.sv
// Purpose: 16x oversample tick and shift-clock edges
// Assumes: timer overflow pulses are one cycle wide and on the same clock
// Notes: runs freely; the user waits for the next fall to begin a bit
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_consts.svh"
module baud_gen
    import serial_port_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic t1_ovf_i,
    input wire logic t2_ovf_i,
    baud_if.gen bif
);

    logic [2:0] m0_cnt_q;
    logic [2:0] m0_last;
    logic half_q;
    logic tmr_ovf;

    // shift-register mode period picked by timing style and rate bit
    always_comb begin
        if (bif.fast) begin
            m0_last = bif.m0_hi ? `SP_M0_FAST_FAST : `SP_M0_FAST_SLOW;
        end else begin
            m0_last = bif.m0_hi ? `SP_M0_COMPAT_FAST : `SP_M0_COMPAT_SLOW;
        end
    end

    assign tmr_ovf = bif.t2_sel ? t2_ovf_i : t1_ovf_i;

    // clock counter for the shift-register bit period
    always_ff @(posedge clk_i) begin
        if (srst_i || m0_cnt_q >= m0_last - 3'd1) begin
            m0_cnt_q <= 3'd0;
        end else begin
            m0_cnt_q <= m0_cnt_q + 3'd1;
        end
    end

    // halving stage shared by timer-driven and fixed rates
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            half_q <= 1'b0;
        end else if (bif.mode == MODE_UART9_FIXED) begin
            half_q <= ~half_q;
        end else if (bif.mode == MODE_SHIFT ? t1_ovf_i : tmr_ovf) begin
            half_q <= ~half_q;
        end
    end

    // oversample tick: fixed clock fraction or timer overflows
    always_comb begin
        if (bif.mode == MODE_UART9_FIXED) begin
            bif.os_tick = bif.dbl | half_q;
        end else if (is_timer_rate(bif.mode)) begin
            bif.os_tick = tmr_ovf & (bif.dbl | half_q);
        end else begin
            bif.os_tick = 1'b0;
        end
    end

    // shift clock edges: alternate timer 1 overflows, or counter at zero and at half the period rounded down
    always_comb begin
        if (bif.m0_tmr) begin
            bif.m0_fall = t1_ovf_i & ~half_q;
            bif.m0_rise = t1_ovf_i & half_q;
        end else begin
            bif.m0_fall = (m0_cnt_q == 3'd0);
            bif.m0_rise = (m0_cnt_q == (m0_last >> 1));
        end
    end

endmodule
`default_nettype wire

// File: rtl/serial_port.sv
// Purpose: full-duplex serial port with shift-register and uart modes
// Assumes: classic Wishbone slave, timer overflows on the same clock
// Notes: interrupt is the or of the two done flags
//
// Summary of operation
// - transmitter and receiver run independently, simultaneously; code holds shift receive while transmitting
// - receiver assembles next byte while one held
// - set receive done flag makes the new byte lost
// - buffer write loads transmit, read returns receive
// - shift mode: data on rxd, clock on txd
// - shift rate 1/6,1/3,1/4,1/2 or timer 1
// - 8-bit frame ten bits, stop into rb8
// - 9-bit frame eleven bits, ninth from tb8
// - 9-bit receive stores ninth bit, not stop
// - fixed 9-bit mode at 1/16 or 1/32
// - variable 9-bit mode uses timer overflows
// - every buffer write starts a transmission
// - shift receive starts when done clear, enabled; code also waits for transmitter idle
// - async receive starts on start bit if enabled
// - interrupt on receive full or transmit done
// - control register bit layout, resets to zero
// - two mode bits select the four modes
// - framing error set by bad stop, software clears
// - bit 7 shows error flag or mode bit
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_consts.svh"
module serial_port
    import serial_port_pkg::*;
(
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic [7:0] ADR_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    input wire logic WE_I,
    input wire logic [3:0] SEL_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    output logic ACK_O,
    output logic ERR_O,
    input wire logic RXD_I,
    output logic RXD_O,
    output logic RXD_OE_O,
    output logic TXD_O,
    input wire logic T1_OVF_I,
    input wire logic T2_OVF_I,
    output logic SERIAL_IRQ_O
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    baud_if bif ();

    logic mode_sel_high_q, mode_sel_low_q, multiproc_enable_q, rx_enable_q;
    logic tx_ninth_bit_q, rx_ninth_bit_q, tx_done_flag_q, rx_done_flag_q;
    logic framing_err_flag_q;
    logic [5:0] cfg_q;
    logic [7:0] rx_buf_q;
    sp_mode_t mode;
    logic wb_req, wb_hit, ctrl_wr, buf_wr, cfg_wr;
    logic rxd_meta_q, rxd_s_q, rxd_prev_q;
    logic tx_busy_q, tx_armed_q, tx_fin_q;
    logic [10:0] tx_shift_q;
    logic [3:0] tx_cnt_q, tx_os_q;
    rx_state_e rx_state_q;
    logic rx_armed_q, rx_fin_q, rx_b9_q;
    logic [8:0] rx_shift_q;
    logic [3:0] rx_cnt_q, rx_os_q;
    logic [7:0] ctrl_rd;
    logic m0_active, rx_accept;

    assign mode = {mode_sel_high_q, mode_sel_low_q};

    ////////////////////////////////////////////////////////////////////////////
    // baud generator

    assign bif.mode = mode;
    assign bif.fast = cfg_q[`SP_FAST_BIT];
    assign bif.m0_hi = cfg_q[`SP_M0HI_BIT];
    assign bif.m0_tmr = cfg_q[`SP_M0TMR_BIT];
    assign bif.dbl = cfg_q[`SP_DBL_BIT];
    assign bif.t2_sel = cfg_q[`SP_T2SEL_BIT];

    baud_gen u_baud (
        .clk_i(CLK_I),
        .srst_i(SRST_I),
        .t1_ovf_i(T1_OVF_I),
        .t2_ovf_i(T2_OVF_I),
        .bif(bif)
    );

    ////////////////////////////////////////////////////////////////////////////
    // wishbone slave

    // request taken once, in the cycle before ack
    assign wb_req = CYC_I & STB_I & ~ACK_O & ~ERR_O;
    assign wb_hit = (ADR_I == `SP_CTRL_OFS) || (ADR_I == `SP_BUF_OFS) ||
        (ADR_I == `SP_CFG_OFS);
    assign ctrl_wr = wb_req & WE_I & SEL_I[0] & (ADR_I == `SP_CTRL_OFS);
    assign buf_wr = wb_req & WE_I & SEL_I[0] & (ADR_I == `SP_BUF_OFS);
    assign cfg_wr = wb_req & WE_I & SEL_I[0] & (ADR_I == `SP_CFG_OFS);

    // bit 7 shows the error flag or the high mode bit
    assign ctrl_rd = {cfg_q[`SP_VIEW_BIT] ? framing_err_flag_q : mode_sel_high_q,
        mode_sel_low_q, multiproc_enable_q, rx_enable_q, tx_ninth_bit_q,
        rx_ninth_bit_q, tx_done_flag_q, rx_done_flag_q};

    // answer one cycle after the request; err if unmapped
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            ACK_O <= 1'b0;
            ERR_O <= 1'b0;
        end else begin
            ACK_O <= wb_req & wb_hit;
            ERR_O <= wb_req & ~wb_hit;
        end
    end

    // read data; buffer reads the separate receive register
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            DAT_O <= 32'h0;
        end else if (wb_req && !WE_I) begin
            unique case (ADR_I)
                `SP_CTRL_OFS: DAT_O <= {24'h0, ctrl_rd};
                `SP_BUF_OFS: DAT_O <= {24'h0, rx_buf_q};
                `SP_CFG_OFS: DAT_O <= {22'h0, (rx_state_q != RX_IDLE), tx_busy_q,
                    2'b00, cfg_q};
                default: DAT_O <= 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control and configuration registers

    // a receive completion is kept only if the receive done flag was cleared
    assign rx_accept = rx_fin_q & ~rx_done_flag_q &
        (rx_state_q == RX_IDLE) &
        (mode == MODE_SHIFT || !is_nine_bit(mode) || !multiproc_enable_q ||
        rx_b9_q);

    // software fields; hardware sets win over a same-cycle clear
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            {mode_sel_high_q, mode_sel_low_q, multiproc_enable_q, rx_enable_q} <= 4'h0;
            tx_ninth_bit_q <= 1'b0;
            tx_done_flag_q <= 1'b0;
            rx_done_flag_q <= 1'b0;
            framing_err_flag_q <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                if (!cfg_q[`SP_VIEW_BIT]) begin
                    mode_sel_high_q <= DAT_I[`SP_SMH_BIT];
                end
                mode_sel_low_q <= DAT_I[`SP_SML_BIT];
                multiproc_enable_q <= DAT_I[`SP_MPE_BIT];
                rx_enable_q <= DAT_I[`SP_REN_BIT];
                tx_ninth_bit_q <= DAT_I[`SP_TB8_BIT];
            end
            tx_done_flag_q <= (ctrl_wr ? DAT_I[`SP_TXDONE_BIT] : tx_done_flag_q) |
                tx_fin_q;
            rx_done_flag_q <= (ctrl_wr ? DAT_I[`SP_RXDONE_BIT] : rx_done_flag_q) |
                rx_accept;
            framing_err_flag_q <= ((ctrl_wr && cfg_q[`SP_VIEW_BIT]) ?
                DAT_I[`SP_SMH_BIT] : framing_err_flag_q) |
                (rx_fin_q & (mode != MODE_SHIFT) & ~rx_shift_q[8]);
        end
    end

    // received byte loaded only on acceptance; ninth bit on acceptance in the uart modes, or on a control write
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            rx_buf_q <= 8'h0;
            rx_ninth_bit_q <= 1'b0;
        end else if (rx_accept) begin
            rx_buf_q <= rx_shift_q[7:0];
            if (is_nine_bit(mode)) begin
                rx_ninth_bit_q <= rx_b9_q;
            end else if (mode == MODE_UART8) begin
                rx_ninth_bit_q <= rx_shift_q[8];
            end
        end else if (ctrl_wr) begin
            rx_ninth_bit_q <= DAT_I[`SP_RB8_BIT];
        end
    end

    // own configuration: bit-7 view, timing style, rate selects
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            cfg_q <= `SP_CFG_RESET;
        end else if (cfg_wr) begin
            cfg_q <= DAT_I[5:0];
        end
    end

    // interrupt request follows the two done flags
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            SERIAL_IRQ_O <= 1'b0;
        end else begin
            SERIAL_IRQ_O <= tx_done_flag_q | rx_done_flag_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive pin synchroniser

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            rxd_meta_q <= 1'b1;
            rxd_s_q <= 1'b1;
            rxd_prev_q <= 1'b1;
        end else begin
            rxd_meta_q <= RXD_I;
            rxd_s_q <= rxd_meta_q;
            rxd_prev_q <= rxd_s_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmitter

    // any buffer write restarts the transmitter
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            tx_busy_q <= 1'b0;
            tx_armed_q <= 1'b0;
            tx_fin_q <= 1'b0;
            tx_shift_q <= 11'h7ff;
            tx_cnt_q <= 4'h0;
            tx_os_q <= 4'h0;
        end else begin
            tx_fin_q <= 1'b0;
            if (buf_wr) begin
                tx_busy_q <= 1'b1;
                tx_armed_q <= 1'b0;
                tx_os_q <= 4'h0;
                if (mode == MODE_SHIFT) begin
                    tx_shift_q <= {3'b111, DAT_I[7:0]};
                    tx_cnt_q <= `SP_BITS8;
                end else if (is_nine_bit(mode)) begin
                    tx_shift_q <= {1'b1, tx_ninth_bit_q, DAT_I[7:0], 1'b0};
                    tx_cnt_q <= `SP_FRAME11;
                end else begin
                    tx_shift_q <= {2'b11, DAT_I[7:0], 1'b0};
                    tx_cnt_q <= `SP_FRAME10;
                end
            end else if (tx_busy_q && mode == MODE_SHIFT) begin
                // bit goes out on the fall, moves on at the rise
                if (bif.m0_fall) begin
                    tx_armed_q <= 1'b1;
                end else if (bif.m0_rise && tx_armed_q) begin
                    tx_shift_q <= {1'b1, tx_shift_q[10:1]};
                    tx_cnt_q <= tx_cnt_q - 4'h1;
                    if (tx_cnt_q == 4'h1) begin
                        tx_busy_q <= 1'b0;
                        tx_fin_q <= 1'b1;
                    end
                end
            end else if (tx_busy_q && bif.os_tick) begin
                tx_os_q <= tx_os_q + 4'h1;
                if (tx_os_q == `SP_OS_LAST) begin
                    tx_shift_q <= {1'b1, tx_shift_q[10:1]};
                    tx_cnt_q <= tx_cnt_q - 4'h1;
                    if (tx_cnt_q == 4'h1) begin
                        tx_busy_q <= 1'b0;
                        tx_fin_q <= 1'b1;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receiver

    // async frames sampled mid-bit; shift mode sampled at clock rise
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            rx_state_q <= RX_IDLE;
            rx_armed_q <= 1'b0;
            rx_fin_q <= 1'b0;
            rx_b9_q <= 1'b0;
            rx_shift_q <= 9'h0;
            rx_cnt_q <= 4'h0;
            rx_os_q <= 4'h0;
        end else begin
            rx_fin_q <= 1'b0;
            unique case (rx_state_q)
                RX_IDLE: begin
                    rx_os_q <= 4'h0;
                    rx_armed_q <= 1'b0;
                    rx_cnt_q <= 4'h0;
                    if (mode == MODE_SHIFT) begin
                        if (!rx_done_flag_q && rx_enable_q && !tx_busy_q && !rx_fin_q) begin
                            rx_state_q <= RX_SHIFT;
                        end
                    end else if (rx_enable_q && rxd_prev_q && !rxd_s_q) begin
                        rx_state_q <= RX_START;
                    end
                end
                RX_SHIFT: begin
                    if (mode != MODE_SHIFT || !rx_enable_q) begin
                        rx_state_q <= RX_IDLE;
                    end else if (bif.m0_fall) begin
                        rx_armed_q <= 1'b1;
                    end else if (bif.m0_rise && rx_armed_q) begin
                        rx_shift_q <= {1'b1, rxd_s_q, rx_shift_q[7:1]};
                        rx_cnt_q <= rx_cnt_q + 4'h1;
                        if (rx_cnt_q == `SP_BITS8 - 4'h1) begin
                            rx_state_q <= RX_IDLE;
                            rx_fin_q <= 1'b1;
                        end
                    end
                end
                RX_START, RX_DATA, RX_STOP: begin
                    if (bif.os_tick) begin
                        rx_os_q <= rx_os_q + 4'h1;
                    end
                    if (bif.os_tick && rx_os_q == `SP_OS_MID) begin
                        if (rx_state_q == RX_START) begin
                            // a start bit that is high again was noise
                            rx_state_q <= rxd_s_q ? RX_IDLE : RX_DATA;
                        end else if (rx_state_q == RX_DATA) begin
                            rx_cnt_q <= rx_cnt_q + 4'h1;
                            if (rx_cnt_q == `SP_BITS8) begin
                                rx_b9_q <= rxd_s_q;
                            end else begin
                                rx_shift_q[7:0] <= {rxd_s_q, rx_shift_q[7:1]};
                            end
                            if (rx_cnt_q == (is_nine_bit(mode) ? `SP_BITS9 : `SP_BITS8) - 4'h1) begin
                                rx_state_q <= RX_STOP;
                            end
                        end else begin
                            // done at mid stop bit so the next edge is seen
                            rx_shift_q[8] <= rxd_s_q;
                            rx_state_q <= RX_IDLE;
                            rx_fin_q <= 1'b1;
                        end
                    end
                end
                default: rx_state_q <= RX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins

    assign m0_active = (mode == MODE_SHIFT) && (tx_busy_q || rx_state_q == RX_SHIFT);

    // txd carries the shift clock in shift mode, the frame otherwise
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            TXD_O <= 1'b1;
        end else if (mode == MODE_SHIFT) begin
            if (!m0_active || bif.m0_rise) begin
                TXD_O <= 1'b1;
            end else if (bif.m0_fall) begin
                TXD_O <= 1'b0;
            end
        end else begin
            TXD_O <= tx_busy_q ? tx_shift_q[0] : 1'b1;
        end
    end

    // rxd driven only while shifting out
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            RXD_O <= 1'b1;
            RXD_OE_O <= 1'b0;
        end else begin
            RXD_OE_O <= (mode == MODE_SHIFT) && tx_busy_q && tx_armed_q;
            if (bif.m0_fall) begin
                RXD_O <= tx_shift_q[0];
            end
        end
    end

endmodule
`default_nettype wire

// File: verif/serial_port_checker.sv
// Purpose: port-level checks of the serial port
// Assumes: one clock, synchronous active-high reset
// Notes: sees only the top ports; bound below
`timescale 1ns/1ps
`default_nettype none
module serial_port_checker (
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic WE_I,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic ACK_O,
    input wire logic ERR_O,
    input wire logic [31:0] DAT_O,
    input wire logic RXD_O,
    input wire logic RXD_OE_O,
    input wire logic TXD_O,
    input wire logic SERIAL_IRQ_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    logic req, map, wctl;
    // request taken this edge; mapped offsets
    assign req = CYC_I && STB_I && !ACK_O && !ERR_O;
    assign map = ADR_I inside {8'h98, 8'h9c, 8'ha0};
    assign wctl = ACK_O && WE_I && ADR_I == 8'h98;
    ////////////////////////////////////////////////////////////////////////////////
    property p_ack; req && map |=> ACK_O && !ERR_O; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_ackp; ACK_O |=> !ACK_O; endproperty
    a_ackp: assert property (p_ackp) else $error("ack held");
    property p_err; req && !map |=> ERR_O && !ACK_O; endproperty
    a_err: assert property (p_err) else $error("no err");
    property p_errd; ERR_O && !WE_I |-> DAT_O == 32'h0; endproperty
    a_errd: assert property (p_errd) else $error("err read nonzero");
    property p_upper; ACK_O && !WE_I && ADR_I != 8'ha0 |-> DAT_O[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper bits set");
    // any buffer write pulls txd low soon
    property p_tx; req && WE_I && SEL_I[0] && ADR_I == 8'h9c |-> ##[1:64] !TXD_O; endproperty
    a_tx: assert property (p_tx) else $error("no transmit");
    property p_shift; RXD_OE_O && $past(RXD_OE_O) && $changed(RXD_O) |-> $fell(TXD_O); endproperty
    a_shift: assert property (p_shift) else $error("data off clock fall");
    // sticky flags: irq falls only after a control write
    property p_irqf; $fell(SERIAL_IRQ_O) |-> $past(wctl); endproperty
    a_irqf: assert property (p_irqf) else $error("irq fell alone");
    c_tx: cover property (req && WE_I && ADR_I == 8'h9c);
    c_irq: cover property ($rose(SERIAL_IRQ_O));
    c_oe: cover property ($rose(RXD_OE_O));
endmodule
bind serial_port serial_port_checker u_chk (.CLK_I(CLK_I), .SRST_I(SRST_I), .ADR_I(ADR_I),
    .SEL_I(SEL_I), .WE_I(WE_I), .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O), .ERR_O(ERR_O),
    .DAT_O(DAT_O), .RXD_O(RXD_O), .RXD_OE_O(RXD_OE_O), .TXD_O(TXD_O),
    .SERIAL_IRQ_O(SERIAL_IRQ_O));
`default_nettype wire

// File: verif/serial_peer.sv
// Purpose: remote serial station on the asynchronous lines
// Assumes: bit length given by the bench in clocks
// Notes: line idles high between frames
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
    input wire logic clk_i,
    input wire logic line_i,
    input wire logic [7:0] per_i,
    input wire logic nine_i,
    output logic line_o
);
    logic [8:0] got_q = 9'h0;
    initial line_o = 1'b1;
    ////////////////////////////////////////////////////////////////////////////////
    // one frame: start low, data lsb first, ninth if enabled, stop
    task automatic send(input logic [8:0] d, input logic stop);
        logic [10:0] f;
        f = nine_i ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
        for (int i = 0; i < (nine_i ? 11 : 10); i++) begin
            @(posedge clk_i);
            line_o <= f[i];
            repeat (per_i - 1) @(posedge clk_i);
        end
        @(posedge clk_i);
        line_o <= 1'b1;
    endtask
    // mid-bit sampling; slot 8 holds the stop bit in 8-bit frames
    initial forever begin
        @(negedge line_i);
        repeat (per_i / 2) @(posedge clk_i);
        for (int i = 0; i < 9; i++) begin
            repeat (per_i) @(posedge clk_i);
            got_q[i] = line_i;
        end
    end
endmodule
`default_nettype wire

// File: verif/serial_port_uart_tb_top.sv
// Purpose: self-checking bench of the serial port
// Assumes: peer on the lines, timer overflow every other cycle
// Notes: 16 clocks per bit in mode 2, 32 in timer modes (double rate)
`timescale 1ns/1ps
`default_nettype none
module serial_port_uart_tb_top;
    logic clk = 1'b0, rst = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0, t1 = 1'b0, t2 = 1'b0;
    logic [7:0] adr = 8'h0, per = 8'd16;
    logic [31:0] dat = 32'h0, rd, q;
    logic [3:0] sel = 4'h1;
    logic ack, err, rxo, rxoe, txd, irq, pl, e, nine = 1'b0;
    logic [1:0] md;
    logic [8:0] tx, rx;
    logic [7:0] sh;
    time t0, t7;
    int miscompares = 0, checks_done = 0, cyc_n = 0;
    wire logic rxw = rxoe ? rxo : pl;
    serial_port u_dut (.CLK_I(clk), .SRST_I(rst), .ADR_I(adr), .DAT_I(dat), .DAT_O(rd),
        .WE_I(we), .SEL_I(sel), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack), .ERR_O(err),
        .RXD_I(rxw), .RXD_O(rxo), .RXD_OE_O(rxoe), .TXD_O(txd), .T1_OVF_I(t1),
        .T2_OVF_I(t2), .SERIAL_IRQ_O(irq));
    serial_peer u_peer (.clk_i(clk), .line_i(txd), .per_i(per), .nine_i(nine), .line_o(pl));
    always #4 clk = ~clk;
    // timer overflows and the hang limit
    always @(posedge clk) begin
        {t1, t2} <= ~{t1, t2};
        cyc_n++;
        if (cyc_n == 20000) begin
            miscompares++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] ex);
        checks_done++;
        if (got !== ex) begin
            miscompares++;
            $display("[ERR] %s exp %h got %h", nm, ex, got);
        end
    endtask
    // classic single cycle; request held until ack or err is sampled
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        {adr, we, dat, cyc, stb} <= {a, w, 24'h0, d, 2'b11};
        do @(posedge clk); while (!(ack || err));
        q = rd;
        e = err;
        {cyc, stb} <= 2'b00;
    endtask
    // poll control until all bits of m set
    task automatic waitf(input logic [7:0] m);
        do wb(8'h98, 1'b0, 8'h0); while ((q[7:0] & m) != m);
    endtask
    function automatic logic [31:0] ctl_exp(input logic [1:0] m, input logic t9, input logic r9);
        return {24'h0, m, 2'b01, t9, (m == 2'd1) | r9, 2'b11};
    endfunction
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(11939));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        wb(8'h98, 1'b0, 8'h0);
        chk("ctrl reset", q, 32'h0);
        wb(8'h44, 1'b0, 8'h0);
        chk("unmapped", {31'h0, e}, 32'h1);
        wb(8'ha0, 1'b1, 8'h10);
        // each async mode: send and receive at once
        for (int i = 1; i < 4; i++) begin
            md = 2'(i);
            tx = 9'($urandom);
            rx = 9'($urandom);
            per <= (md == 2'd2) ? 8'd16 : 8'd32;
            nine <= md != 2'd1;
            wb(8'h98, 1'b1, {md, 2'b01, tx[8], 3'b000});
            wb(8'h9c, 1'b1, tx[7:0]);
            u_peer.send(rx, 1'b1);
            waitf(8'h03);
            chk("ctrl", q, ctl_exp(md, tx[8], rx[8]));
            chk("line", 32'(u_peer.got_q), md == 2'd1 ? {1'b1, tx[7:0]} : tx);
            chk("irq", {31'h0, irq}, 32'h1);
            wb(8'h9c, 1'b0, 8'h0);
            chk("rx byte", q, {24'h0, rx[7:0]});
        end
        // overrun keeps the held byte while the receive done flag is still set
        u_peer.send(9'($urandom), 1'b1);
        repeat (32) @(posedge clk);
        wb(8'h9c, 1'b0, 8'h0);
        chk("overrun", q, {24'h0, rx[7:0]});
        // mode before view, which diverts bit 7; error flag sticks
        wb(8'h98, 1'b1, 8'h90);
        wb(8'ha0, 1'b1, 8'h11);
        per <= 8'd16;
        nine <= 1'b1;
        u_peer.send(9'($urandom), 1'b0);
        u_peer.send(9'($urandom), 1'b1);
        repeat (32) @(posedge clk);
        wb(8'h98, 1'b0, 8'h0);
        chk("frame err", {31'h0, q[7]}, 32'h1);
        // address filter drops ninth bit low
        wb(8'ha0, 1'b1, 8'h10);
        wb(8'h98, 1'b1, 8'hb0);
        u_peer.send({1'b0, 8'($urandom)}, 1'b1);
        repeat (32) @(posedge clk);
        wb(8'h98, 1'b0, 8'h0);
        chk("filtered", {31'h0, q[0]}, 32'h0);
        rx = {1'b1, 8'($urandom)};
        u_peer.send(rx, 1'b1);
        waitf(8'h01);
        wb(8'h9c, 1'b0, 8'h0);
        chk("addressed", q, {24'h0, rx[7:0]});
        // shift mode transmit at 1/6 clock
        tx = 9'($urandom);
        wb(8'h98, 1'b1, 8'h00);
        wb(8'h9c, 1'b1, tx[7:0]);
        for (int i = 0; i < 8; i++) begin
            @(posedge txd);
            sh[i] = rxo;
            if (i == 0) t0 = $time;
            t7 = $time;
        end
        chk("shift data", {24'h0, sh}, {24'h0, tx[7:0]});
        chk("shift rate", 32'((t7 - t0) / 56), 32'd6);
        finish_test();
    end
endmodule
`default_nettype wire
